// [ext_bus_port.sv]
// Shared external bus port: master access, slave waits, host hand-over, arbitration
//
// Functional notes
// - Master drives address lines for external accesses
// - Slave samples address lines driven by others
// - Four active-low bank chip selects, size configurable
// - Bank selects decoded with address, same cycle
// - Bank selects inactive when no external access
// - Conditional access asserts selects regardless of condition
// - Only master drives selects, page, address clock
// - Read strobe low on external reads
// - Others must drive read strobe; slave takes it
// - Write strobe: external writes, slave input
// - Page output flags DRAM page boundary crossing
// - Page output only on bank 0 accesses
// - Low acknowledge stretches master access
// - Slave drives acknowledge low for wait states
// - Acknowledge input keeps last driven level
// - Host request makes master yield, assert grant
// - Yielding master floats address, data, selects, strobes
// - Host request beats every processor request
// - Single processor holds grant low until host releases request
// - Drive own request line, watch the others
// - Rotating priority when select high, else fixed
`timescale 1ns/100ps
`default_nettype none
module ext_bus_port #(
  parameter int ADDR_W = ext_bus_pkg::ADDR_W,
  parameter int DATA_W = ext_bus_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Core side master request
  input  wire logic              core_req,
  input  wire logic              core_we,
  input  wire logic              core_cond,
  input  wire logic [ADDR_W-1:0] core_addr,
  input  wire logic [DATA_W-1:0] core_wdata,
  output logic                   core_done,
  output logic      [DATA_W-1:0] core_rdata,
  // Slave side toward internal memory
  output logic                   slv_req,
  output logic                   slv_we,
  output logic      [ADDR_W-1:0] slv_addr,
  output logic      [DATA_W-1:0] slv_wdata,
  input  wire logic              slv_ready,
  input  wire logic [DATA_W-1:0] slv_rdata,
  // Configuration
  input  wire logic [4:0]        bank_size_log2,
  input  wire logic [4:0]        page_size_log2,
  input  wire logic              ready_drive_mode_bit,
  input  wire logic [2:0]        core_identity_inputs,
  input  wire logic              rotating_priority_select,
  // External bus pins
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   addr_oe_n,
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   data_oe_n,
  output logic      [3:0]        memory_bank_select_n,
  output logic                   ctl_oe_n,
  input  wire logic              rd_n_i,
  output logic                   rd_n_o,
  input  wire logic              wr_n_i,
  output logic                   wr_n_o,
  output logic                   strobe_oe_n,
  input  wire logic              ack_i,
  input  wire logic              ack_line_driven,
  output logic                   ack_o,
  output logic                   ack_oe_n,
  output logic                   dram_page_boundary,
  output logic                   address_reference_clock_out,
  input  wire logic              suspend_bus_tristate_n,
  input  wire logic              host_bus_request_n,
  input  wire logic              host_bus_grant_n_i,
  output logic                   host_bus_grant_n_o,
  output logic                   host_bus_grant_oe_n,
  input  wire logic [3:0]        core_select_n,
  output logic                   host_ready_ack,
  output logic                   host_ready_oe_n,
  input  wire logic [6:1]        arbitration_request_lines_i,
  output logic      [6:1]        arbitration_request_lines_o,
  output logic      [6:1]        arbitration_request_lines_oe_n
);
  localparam int SW = ADDR_W + DATA_W + 17;
  // Pin register plus two sync flops before acknowledge is trusted
  localparam logic [1:0] ACK_LAT = 2'h3;

  // Two-flop synchronisers for every pin input except host_bus_grant_n_i
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= '1;
      s2_reg <= '1;
    end else begin
      s1_reg <= {addr_i, data_i, rd_n_i, wr_n_i, ack_i, ack_line_driven,
                 suspend_bus_tristate_n, host_bus_request_n, core_select_n,
                 arbitration_request_lines_i, rotating_priority_select};
      s2_reg <= s1_reg;
    end
  end
  logic [ADDR_W-1:0] a_s;
  logic [DATA_W-1:0] d_s;
  logic rd_s, wr_s, ack_s, ackdrv_s, suspend_bus_tristate_n_s, hbr_s, rot_s;
  logic [3:0] cs_s;
  logic [6:1] br_s;
  assign {a_s, d_s, rd_s, wr_s, ack_s, ackdrv_s, suspend_bus_tristate_n_s, hbr_s, cs_s,
          br_s, rot_s} = s2_reg;

  // Keeper on acknowledge
  logic ack_keep_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ack_keep_reg <= 1'b1;
    else if (ackdrv_s)
      ack_keep_reg <= ack_s;
  end
  logic ack_now;
  assign ack_now = ackdrv_s ? ack_s : ack_keep_reg;

  // Arbitration
  logic [2:0] id;
  logic       single;
  assign id = core_identity_inputs;
  assign single = (id == ext_bus_pkg::ID_SINGLE);

  ext_bus_pkg::master_state_e st_reg;
  logic [2:0] owner_reg;
  logic [2:0] last_reg;
  logic own_req;
  logic [6:1] req_all;
  logic [2:0] winner;
  logic [2:0] cand;
  logic is_master;

  assign own_req = (st_reg != ext_bus_pkg::ST_IDLE) && (st_reg != ext_bus_pkg::ST_HOST);
  always_comb begin
    req_all = ~br_s;
    if (!single)
      req_all[id] = own_req;
  end
  // Fixed: lowest line wins; rotating: first after last master
  always_comb begin
    winner = 3'h0;
    cand = 3'h0;
    for (int k = 6; k >= 1; k--) begin
      if (req_all[k])
        winner = 3'(k);
    end
    if (rot_s) begin
      for (int k = 5; k >= 0; k--) begin
        cand = 3'((int'(last_reg) + k) % 6 + 1);
        if (req_all[cand])
          winner = cand;
      end
    end
  end
  // Every processor tracks the same owner from the shared lines
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      owner_reg <= 3'h0;
      last_reg <= 3'h6;
    end else if (owner_reg == 3'h0 || !req_all[owner_reg]) begin
      if (!hbr_s)
        owner_reg <= 3'h0;
      else begin
        owner_reg <= winner;
        if (winner != 3'h0)
          last_reg <= winner;
      end
    end
  end
  assign is_master = single || (owner_reg == id);

  // Master state machine
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              we_reg;
  logic [1:0]        ack_seen_reg;
  logic              pend_reg;
  logic              take;
  // Request held over a host tenure is taken once and kept pending
  assign take = (st_reg == ext_bus_pkg::ST_IDLE || st_reg == ext_bus_pkg::ST_HOST)
                && core_req && !pend_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= ext_bus_pkg::ST_IDLE;
      ack_seen_reg <= 2'h0;
    end else begin
      ack_seen_reg <= 2'h0;
      unique case (st_reg)
        ext_bus_pkg::ST_IDLE: begin
          if (!hbr_s && is_master)
            st_reg <= ext_bus_pkg::ST_HOST;
          else if (core_req)
            st_reg <= ext_bus_pkg::ST_ARB;
        end
        ext_bus_pkg::ST_ARB: begin
          if (!hbr_s && is_master)
            st_reg <= ext_bus_pkg::ST_HOST;
          else if (is_master && hbr_s)
            st_reg <= ext_bus_pkg::ST_TURN;
        end
        ext_bus_pkg::ST_TURN:
          st_reg <= ext_bus_pkg::ST_ACCESS;
        ext_bus_pkg::ST_ACCESS: begin
          if (!suspend_bus_tristate_n_s)
            ack_seen_reg <= 2'h0;
          else if (ack_seen_reg != ACK_LAT)
            ack_seen_reg <= ack_seen_reg + 2'h1;
          else if (ack_now)
            st_reg <= ext_bus_pkg::ST_DONE;
        end
        ext_bus_pkg::ST_DONE: begin
          if (!hbr_s)
            st_reg <= ext_bus_pkg::ST_HOST;
          else
            st_reg <= ext_bus_pkg::ST_IDLE;
        end
        ext_bus_pkg::ST_HOST: begin
          if (hbr_s)
            st_reg <= pend_reg ? ext_bus_pkg::ST_ARB : ext_bus_pkg::ST_IDLE;
        end
        default:
          st_reg <= ext_bus_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_reg <= ext_bus_pkg::ADDR_RST;
      wdata_reg <= ext_bus_pkg::DATA_RST;
      we_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else if (take) begin
      pend_reg <= 1'b1;
      addr_reg <= core_addr;
      wdata_reg <= core_wdata;
      we_reg <= core_we;
    end else if (st_reg == ext_bus_pkg::ST_DONE) begin
      pend_reg <= 1'b0;
    end
  end

  logic driving;
  logic active;
  assign active = (st_reg == ext_bus_pkg::ST_ACCESS);
  // Outputs float on suspend or when not master
  assign driving = active && suspend_bus_tristate_n_s && is_master;

  // Bank decode; condition flag does not gate the select
  logic [ADDR_W-1:0] bank_idx;
  logic              bank_hit;
  logic [3:0]        sel_dec;
  assign bank_idx = addr_reg >> bank_size_log2;
  assign bank_hit = (bank_idx < ADDR_W'(ext_bus_pkg::BANKS)) && !core_cond | (bank_idx < ADDR_W'(ext_bus_pkg::BANKS));
  always_comb begin
    sel_dec = 4'hf;
    if (active && bank_hit)
      sel_dec[bank_idx[1:0]] = 1'b0;
  end

  // Pin outputs registered; address and selects change together
  logic [ADDR_W-1:0] addr_q;
  logic [3:0]        sel_q;
  logic              rd_q, wr_q, drv_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= ext_bus_pkg::ADDR_RST;
      sel_q <= 4'hf;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      drv_q <= 1'b0;
    end else begin
      addr_q <= addr_reg;
      sel_q <= sel_dec;
      rd_q <= !(active && !we_reg);
      wr_q <= !(active && we_reg);
      drv_q <= driving;
    end
  end
  assign addr_o = addr_q;
  assign data_o = wdata_reg;
  assign memory_bank_select_n = sel_q;
  assign rd_n_o = rd_q;
  assign wr_n_o = wr_q;
  assign addr_oe_n = !drv_q;
  assign data_oe_n = !(drv_q && we_reg);
  assign strobe_oe_n = !drv_q;
  assign ctl_oe_n = !drv_q;

  // DRAM page boundary on bank 0
  logic [ADDR_W-1:0] page_last_reg;
  logic [ADDR_W-1:0] page_now;
  logic              page_reg;
  assign page_now = addr_reg >> page_size_log2;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_last_reg <= '1;
      page_reg <= 1'b0;
    end else begin
      page_reg <= 1'b0;
      if (st_reg == ext_bus_pkg::ST_TURN && !sel_dec_b0()) begin
        page_reg <= (page_now != page_last_reg);
        page_last_reg <= page_now;
      end
    end
  end
  function automatic logic sel_dec_b0();
    return !(bank_hit && bank_idx[1:0] == ext_bus_pkg::DRAM_BANK);
  endfunction
  assign dram_page_boundary = page_reg;

  // Address reference clock, half rate
  logic address_reference_clock_out_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      address_reference_clock_out_reg <= 1'b0;
    else
      address_reference_clock_out_reg <= !address_reference_clock_out_reg;
  end
  assign address_reference_clock_out = address_reference_clock_out_reg & is_master;

  // Master read data and completion
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_done <= 1'b0;
      core_rdata <= ext_bus_pkg::DATA_RST;
    end else begin
      core_done <= (st_reg == ext_bus_pkg::ST_DONE);
      if (active && suspend_bus_tristate_n_s && ack_seen_reg == ACK_LAT && ack_now && !we_reg)
        core_rdata <= d_s;
    end
  end

  // Host grant
  assign host_bus_grant_n_o = !(st_reg == ext_bus_pkg::ST_HOST);
  assign host_bus_grant_oe_n = !is_master;

  // Request line: own line only
  always_comb begin
    arbitration_request_lines_o = '1;
    arbitration_request_lines_oe_n = '1;
    if (!single) begin
      arbitration_request_lines_o[id] = !own_req;
      arbitration_request_lines_oe_n[id] = 1'b0;
    end
  end

  // Slave access of internal memory
  logic sync_acc, host_acc, slv_busy_reg, slv_done_reg;
  assign sync_acc = !is_master && (!rd_s || !wr_s)
                    && (a_s < ext_bus_pkg::INT_SPACE_TOP);
  assign host_acc = (cs_s != 4'hf) && (!rd_s || !wr_s);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slv_busy_reg <= 1'b0;
      slv_we <= 1'b0;
      slv_addr <= ext_bus_pkg::ADDR_RST;
      slv_wdata <= ext_bus_pkg::DATA_RST;
    end else if (!slv_busy_reg && !slv_done_reg && (sync_acc || host_acc)) begin
      slv_busy_reg <= 1'b1;
      slv_we <= !wr_s;
      slv_addr <= a_s;
      slv_wdata <= d_s;
    end else if (slv_busy_reg && slv_ready) begin
      slv_busy_reg <= 1'b0;
    end
  end
  // One internal access per strobe assertion
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      slv_done_reg <= 1'b0;
    else if (!(sync_acc || host_acc))
      slv_done_reg <= 1'b0;
    else if (slv_busy_reg && slv_ready)
      slv_done_reg <= 1'b1;
  end
  assign slv_req = slv_busy_reg;
  assign ack_o = !(slv_busy_reg && !slv_ready);
  assign ack_oe_n = !(slv_busy_reg && sync_acc);
  // Ready: open drain unless active drive chosen
  logic host_wait;
  assign host_wait = slv_busy_reg && host_acc && !slv_ready;
  assign host_ready_ack = !host_wait;
  assign host_ready_oe_n = !(host_wait || (ready_drive_mode_bit && host_acc));

  a_sel_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(active) |-> memory_bank_select_n == 4'hf)
    else $error("bank select active outside access");
  a_sel_float: assert property (@(posedge clk) disable iff (!rst_b)
    !is_master && !single |=> ##1 ctl_oe_n || $past(is_master, 2))
    else $error("non-master drives selects");
  a_suspend_flt: assert property (@(posedge clk) disable iff (!rst_b)
    !suspend_bus_tristate_n_s ##1 !suspend_bus_tristate_n_s |-> addr_oe_n && strobe_oe_n)
    else $error("outputs driven during suspend");
  a_ack_stall: assert property (@(posedge clk) disable iff (!rst_b)
    active && !ack_now |=> st_reg != ext_bus_pkg::ST_DONE)
    else $error("access ended while acknowledge low");
  a_grant_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !host_bus_grant_n_o && !hbr_s |=> !host_bus_grant_n_o)
    else $error("grant dropped while host requests");
  a_host_first: assert property (@(posedge clk) disable iff (!rst_b)
    !hbr_s && owner_reg == 3'h0 |=> owner_reg == 3'h0)
    else $error("processor won bus over host");
  a_page_bank0: assert property (@(posedge clk) disable iff (!rst_b)
    dram_page_boundary |-> $past(bank_hit && bank_idx[1:0] == ext_bus_pkg::DRAM_BANK))
    else $error("page flagged outside bank 0");
  a_turn_gap: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(active) |-> $past(st_reg) == ext_bus_pkg::ST_TURN)
    else $error("access without turnaround");
  a_yield_flt: assert property (@(posedge clk) disable iff (!rst_b)
    st_reg == ext_bus_pkg::ST_HOST ##1 st_reg == ext_bus_pkg::ST_HOST |-> addr_oe_n && data_oe_n)
    else $error("bus driven while host owns it");
  a_slave_wait: assert property (@(posedge clk) disable iff (!rst_b)
    slv_busy_reg && sync_acc && !slv_ready |-> !ack_oe_n && !ack_o)
    else $error("slave wait not signalled");
endmodule
`default_nettype wire

// [ext_bus_pkg.sv]
// Constants and state types for the shared external bus port
package ext_bus_pkg;
  localparam int ADDR_W    = 32;
  localparam int DATA_W    = 48;
  localparam int BANKS     = 4;
  localparam int REQ_LINES = 6;
  localparam int ID_W      = 3;
  // Bank 0 is the only bank that may hold DRAM
  localparam logic [1:0] DRAM_BANK = 2'h0;
  // Slave internal space sits below this address
  localparam logic [31:0] INT_SPACE_TOP = 32'h0010_0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [47:0] DATA_RST = 48'h0000_0000_0000;
  localparam logic [2:0] ID_SINGLE = 3'h0;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ARB    = 3'b001,
    ST_TURN   = 3'b010,
    ST_ACCESS = 3'b011,
    ST_DONE   = 3'b100,
    ST_HOST   = 3'b101
  } master_state_e;
endpackage

// [ext_mem_model.sv]
// Far-side model: external memory with wait states and other bus masters
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
  input  wire logic        clk,
  input  wire logic [31:0] addr_o,
  input  wire logic        rd_n_o,
  input  wire logic        strobe_oe_n,
  input  wire logic [3:0]  memory_bank_select_n,
  input  wire logic        ack_stall,
  input  wire logic [6:1]  other_req_n,
  input  wire logic [6:1]  arb_o,
  input  wire logic [6:1]  arb_oe_n,
  output logic             ack_i,
  output logic             ack_line_driven,
  output logic [47:0]      data_i,
  output logic [6:1]       arb_i
);
  logic        sel_any;
  logic        rd;
  logic        last_ack;
  logic [47:0] last_d;
  assign sel_any = !strobe_oe_n && (memory_bank_select_n != 4'hf);
  assign rd = !strobe_oe_n && !rd_n_o;
  // Ack only driven in a selected access; low while stalled
  assign ack_line_driven = sel_any;
  // Undriven ack shows the opposite level; the keeper must hide it
  assign ack_i = sel_any ? !ack_stall : !last_ack;
  assign data_i = rd ? {16'ha5c3, addr_o} : ~last_d;
  // Lines not driven by the port carry the other masters' requests from other_req_n
  assign arb_i = (~arb_oe_n & arb_o) | (arb_oe_n & other_req_n);
  always_ff @(posedge clk) begin
    if (sel_any) begin
      last_ack <= !ack_stall;
    end
    if (rd) begin
      last_d <= data_i;
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking testbench for the shared external bus port
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst_b = 1'b0;
  logic core_req, core_we, core_cond, core_done, slv_req, slv_we, slv_ready;
  logic ready_drive_mode_bit, rotating_priority_select, ack_stall, ack_i, ack_line_driven;
  logic addr_oe_n, data_oe_n, ctl_oe_n, rd_n_i, rd_n_o, wr_n_i, wr_n_o, strobe_oe_n;
  logic dram_page_boundary, suspend_bus_tristate_n, host_bus_request_n, host_rd_n;
  logic host_bus_grant_n_i, host_bus_grant_n_o, host_bus_grant_oe_n, host_ready_ack, host_ready_oe_n;
  logic [2:0]  core_identity_inputs;
  logic [3:0]  memory_bank_select_n, core_select_n;
  logic [4:0]  bank_size_log2, page_size_log2;
  logic [6:1]  arbitration_request_lines_i, arbitration_request_lines_o, arbitration_request_lines_oe_n;
  logic [6:1]  other_req_n;
  logic [31:0] core_addr, addr_i, addr_o, host_addr, slv_addr;
  logic [47:0] core_wdata, core_rdata, data_i;
  int          err_total = 0;
  int          cmp_count = 0;
  assign addr_i = addr_oe_n ? host_addr : addr_o;
  assign rd_n_i = strobe_oe_n ? host_rd_n : rd_n_o;
  assign wr_n_i = strobe_oe_n ? 1'b1 : wr_n_o;
  assign host_bus_grant_n_i = host_bus_grant_oe_n | host_bus_grant_n_o;
  always #20 clk = ~clk;
  ext_bus_port uut (.clk, .rst_b, .core_req, .core_we, .core_cond, .core_addr, .core_wdata,
    .core_done, .core_rdata, .slv_req, .slv_we, .slv_addr, .slv_wdata(), .slv_ready,
    .slv_rdata(48'h0), .bank_size_log2, .page_size_log2, .ready_drive_mode_bit,
    .core_identity_inputs, .rotating_priority_select, .addr_i, .addr_o, .addr_oe_n, .data_i,
    .data_o(), .data_oe_n, .memory_bank_select_n, .ctl_oe_n, .rd_n_i, .rd_n_o, .wr_n_i, .wr_n_o,
    .strobe_oe_n, .ack_i, .ack_line_driven, .ack_o(), .ack_oe_n(), .dram_page_boundary,
    .address_reference_clock_out(), .suspend_bus_tristate_n, .host_bus_request_n,
    .host_bus_grant_n_i, .host_bus_grant_n_o, .host_bus_grant_oe_n, .core_select_n,
    .host_ready_ack, .host_ready_oe_n, .arbitration_request_lines_i,
    .arbitration_request_lines_o, .arbitration_request_lines_oe_n);
  ext_mem_model partner (.clk, .addr_o, .rd_n_o, .strobe_oe_n, .memory_bank_select_n, .ack_stall,
    .other_req_n, .arb_o(arbitration_request_lines_o), .arb_oe_n(arbitration_request_lines_oe_n),
    .ack_i, .ack_line_driven, .data_i, .arb_i(arbitration_request_lines_i));
  task automatic chk(input logic [47:0] seen, exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s seen=%h exp=%h", $time, m, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tmo(input string m);
    err_total++;
    $display("CHECK FAILED t=%0t timeout %s", $time, m);
    summarize();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic go(input logic we, cond, input logic [31:0] a);
    @(posedge clk);
    core_we <= we;
    core_cond <= cond;
    core_addr <= a;
    core_wdata <= {16'h5a5a, a};
    core_req <= 1'b1;
    @(posedge clk);
    core_req <= 1'b0;
  endtask
  task automatic wdone(input int lim, input string m);
    int n;
    for (n = 0; n < lim && core_done !== 1'b1; n++) cyc(1);
    if (n == lim) tmo(m);
  endtask
  task automatic rst(input logic [2:0] id);
    rst_b <= 1'b0;
    core_identity_inputs <= id;
    cyc(3);
    chk({memory_bank_select_n, addr_oe_n, ctl_oe_n, strobe_oe_n, host_bus_grant_oe_n, core_done},
      {7'h7f, id != 3'h0, 1'b0}, "reset");
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic acc(input logic we, cond, input logic [31:0] a,
                     output logic [3:0] s, output logic [31:0] ad, output int low, pg);
    int n;
    low = 0;
    pg = 0;
    s = 4'hf;
    ad = 32'h0;
    go(we, cond, a);
    for (n = 0; n < 60 && core_done !== 1'b1; n++) begin
      cyc(1);
      if (!strobe_oe_n && !(we ? wr_n_o : rd_n_o)) begin
        if (low == 0) begin
          s = memory_bank_select_n;
          ad = addr_o;
        end
        low++;
      end
      pg += int'(dram_page_boundary === 1'b1);
    end
    if (n == 60) tmo("access");
    cyc(1);
    pg += int'(dram_page_boundary === 1'b1);
  endtask
  task automatic t_banks;
    logic [31:0] a [3] = '{32'h0030_0010, 32'h0010_0000, 32'h0050_0000};
    logic [3:0]  e [3] = '{4'h7, 4'hd, 4'hf};
    logic [3:0]  s;
    logic [31:0] ad;
    int          low, pg;
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, 1'b1, a[i], s, ad, low, pg);
      chk(s, e[i], "bank select");
      chk(ad, a[i], "address");
      chk(low > 0, 1'b1, "read strobe");
      chk(memory_bank_select_n, 4'hf, "idle select");
    end
    acc(1'b1, 1'b0, 32'h0020_0004, s, ad, low, pg);
    chk(s, 4'hb, "false condition select");
    chk(low > 0, 1'b1, "write strobe");
  endtask
  task automatic t_page;
    logic [31:0] a [6] = '{32'h10, 32'h120, 32'h130, 32'h0010_0010, 32'h0010_0220, 32'h0010_0230};
    logic        e [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic [3:0]  s;
    logic [31:0] ad;
    int          low, pg;
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, 1'b1, a[i], s, ad, low, pg);
      if (i != 0) chk(pg > 0, e[i], "page boundary");
    end
  endtask
  task automatic t_ack;
    @(posedge clk);
    ack_stall <= 1'b1;
    go(1'b0, 1'b1, 32'h0010_0040);
    cyc(12);
    chk({rd_n_o, strobe_oe_n, core_done}, 3'h0, "wait state");
    @(posedge clk);
    ack_stall <= 1'b0;
    wdone(20, "ack");
    chk(core_rdata, {16'ha5c3, 32'h0010_0040}, "read data");
  endtask
  task automatic t_host;
    @(posedge clk);
    host_bus_request_n <= 1'b0;
    cyc(8);
    chk({host_bus_grant_n_o, host_bus_grant_oe_n}, 2'h0, "grant");
    chk({addr_oe_n, data_oe_n, ctl_oe_n, strobe_oe_n}, 4'hf, "float");
    go(1'b0, 1'b1, 32'h0030_0000);
    cyc(20);
    chk({host_bus_grant_n_o, core_done, strobe_oe_n}, 3'h1, "grant held");
    @(posedge clk);
    host_bus_request_n <= 1'b1;
    wdone(30, "host");
    chk(host_bus_grant_n_o | host_bus_grant_oe_n, 1'b1, "grant off");
  endtask
  task automatic t_susp;
    @(posedge clk);
    suspend_bus_tristate_n <= 1'b0;
    cyc(4);
    go(1'b1, 1'b1, 32'h0010_0008);
    cyc(20);
    chk({addr_oe_n, data_oe_n, ctl_oe_n, strobe_oe_n, core_done}, 5'h1e, "suspend");
    @(posedge clk);
    suspend_bus_tristate_n <= 1'b1;
    wdone(30, "suspend");
  endtask
  task automatic t_slave;
    int n;
    @(posedge clk);
    host_bus_request_n <= 1'b0;
    cyc(8);
    core_select_n <= 4'he;
    host_addr <= 32'h100;
    host_rd_n <= 1'b0;
    cyc(8);
    chk({slv_req, slv_we, host_ready_oe_n, host_ready_ack}, 4'h8, "slave wait");
    chk(slv_addr, 32'h100, "slave address");
    @(posedge clk);
    slv_ready <= 1'b1;
    for (n = 0; n < 10 && host_ready_ack !== 1'b1; n++) cyc(1);
    if (n == 10) tmo("ready");
    @(posedge clk);
    {core_select_n, host_rd_n, slv_ready, host_bus_request_n} <= 7'h7d;
    cyc(8);
  endtask
  task automatic t_arb;
    @(posedge clk);
    other_req_n <= 6'h3e;
    rst(3'h2);
    go(1'b0, 1'b1, 32'h0010_0000);
    cyc(12);
    chk({arbitration_request_lines_oe_n, arbitration_request_lines_o[2]}, 7'h7a, "own line");
    chk({strobe_oe_n, core_done}, 2'h2, "lower line wins");
    @(posedge clk);
    other_req_n <= 6'h3f;
    wdone(40, "arbitration");
  endtask
  initial begin
    {core_req, core_we, core_cond, slv_ready, ready_drive_mode_bit, rotating_priority_select} = 6'h08;
    {ack_stall, suspend_bus_tristate_n, host_bus_request_n, host_rd_n} = 4'h7;
    core_identity_inputs = 3'h0;
    core_select_n = 4'hf;
    bank_size_log2 = 5'h14;
    page_size_log2 = 5'h08;
    other_req_n = 6'h3f;
    core_addr = 32'h0;
    host_addr = 32'h0;
    core_wdata = 48'h0;
    rst(3'h0);
    t_banks();
    t_page();
    t_ack();
    t_host();
    t_susp();
    t_slave();
    t_arb();
    summarize();
  end
endmodule
`default_nettype wire
